// File: hdl/aeq_pkg.sv
// Constants for the adaptive equalizer search controller.
// Assumes a 200 MHz system clock and a byte-wide register port.
package aeq_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] AEQ_CTL_ONE_OFS  = 8'h35;
  localparam logic [7:0] EQUALIZER_ADAPT_STATUS_OFS   = 8'h3b;
  localparam logic [7:0] AEQ_CTL_TWO_OFS  = 8'h45;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  // equalizer_control_one
  localparam int ADAPT_RESTART_BIT     = 0;
  localparam int AEQ_FLOOR_APPLY_BIT = 1;
  localparam int AEQ_FLOOR_OVR_BIT   = 2;
  // equalizer_control_two
  localparam int AEQ_FLOOR_LSB       = 4;
  localparam int AEQ_DWELL_LSB       = 0;
  // equalizer_adapt_status
  localparam int AEQ_ST_GAIN_LSB     = 0;
  localparam int AEQ_ST_HOLD_BIT     = 4;
  localparam int AEQ_ST_LOCK_BIT     = 5;

  // ---------------------------------------------------------------------
  // Widths, limits and reset values
  // ---------------------------------------------------------------------
  localparam int         AEQ_GAIN_W     = 4;
  localparam int         AEQ_DWELL_W    = 3;
  localparam int         AEQ_CNT_W      = 24;
  localparam logic [3:0] AEQ_GAIN_MIN   = 4'h0;
  localparam logic [3:0] AEQ_GAIN_MAX   = 4'hf;
  localparam logic [3:0] AEQ_FLOOR_RST  = 4'h0;
  localparam logic [2:0] AEQ_DWELL_RST  = 3'h3;
  localparam logic [1:0] EQUALIZER_CONTROL_ONE_RST   = 2'h0;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int AEQ_CLK_PERIOD_PS = 5000;
  // Default dwell per setting, 2.62 ms
  localparam int AEQ_DWELL_DEF_NS  = 2620000;
  localparam int AEQ_DWELL_DEF_CYC =
    (AEQ_DWELL_DEF_NS / AEQ_CLK_PERIOD_PS) * 1000;
  // Dwell doubles per code step; default code lands on the default time
  localparam int AEQ_DWELL_BASE_CYC =
    AEQ_DWELL_DEF_CYC >> AEQ_DWELL_RST;

  typedef enum logic {AEQ_ST_DWELL, AEQ_ST_HOLD} aeq_state_t;

endpackage

// File: hdl/aeq_search_ctrl.sv
// Adaptive equalizer search controller with its two control registers and status register.
// Assumes cdr_lock arrives asynchronously from the recovery circuit and
// that the register port strobes come from logic on clk_sys.
//
// How it works
// - Search gain settings upward in index order
// - Wait dwell time, then evaluate lock
// - Hold gain unchanged while lock persists
// - On lock loss advance to next setting
// - Restart bit restarts adaptation at any time
// - Search runs from reset without enabling write
// - Floor field sets pass starting gain index
// - Floor used only with override and apply
// - Top of range fixed at maximum setting
// - Current gain readable from status register
// - Dwell field defaults to 2.62 ms
// - No lock at maximum wraps to start
`timescale 1ns/1ps

module aeq_search_ctrl
  import aeq_pkg::*;
#(
  parameter int DWELL_BASE_CYC = AEQ_DWELL_BASE_CYC
)(
  input  wire logic       clk_sys,    // System clock, 200 MHz
  input  wire logic       rst_n,      // Synchronous reset, active low
  input  wire logic [7:0] reg_addr,   // Register offset
  input  wire logic [7:0] reg_wdata,  // Write data
  input  wire logic       reg_wr,     // Write strobe, one cycle
  input  wire logic       reg_rd,     // Read strobe, one cycle
  output logic      [7:0] reg_rdata,  // Read data, valid after reg_rd
  input  wire logic       cdr_lock,   // Lock from recovery circuit, async
  output logic      [3:0] eq_gain,    // Gain index to the equalizer
  output logic            eq_locked   // Setting held on valid lock
);

  // -----------------------------------------------------------------------
  // Register port
  // -----------------------------------------------------------------------
  logic [1:0]  ctl1_q;
  logic [1:0]  ctl1_d;
  logic [3:0]  floor_q;
  logic [3:0]  floor_d;
  logic [2:0]  dwell_sel_q;
  logic [2:0]  dwell_sel_d;
  logic        restart_q;
  logic        restart_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  wire logic   wr_ctl1 = reg_wr && (reg_addr == AEQ_CTL_ONE_OFS);
  wire logic   wr_ctl2 = reg_wr && (reg_addr == AEQ_CTL_TWO_OFS);
  wire logic [7:0] ctl1_rd = {5'h00, ctl1_q, 1'b0};
  wire logic [7:0] ctl2_rd = {floor_q, 1'b0, dwell_sel_q};
  logic [7:0]  status_rd;

  // Restart is a write-one pulse that reads back as zero
  assign restart_d   = wr_ctl1 && reg_wdata[ADAPT_RESTART_BIT];
  assign ctl1_d      = wr_ctl1 ? reg_wdata[AEQ_FLOOR_OVR_BIT:
                                           AEQ_FLOOR_APPLY_BIT] : ctl1_q;
  assign floor_d     = wr_ctl2 ? reg_wdata[AEQ_FLOOR_LSB +: AEQ_GAIN_W]
                               : floor_q;
  assign dwell_sel_d = wr_ctl2 ? reg_wdata[AEQ_DWELL_LSB +: AEQ_DWELL_W]
                               : dwell_sel_q;
  assign rdata_d     = !reg_rd                       ? rdata_q :
                       (reg_addr == AEQ_CTL_ONE_OFS) ? ctl1_rd :
                       (reg_addr == AEQ_CTL_TWO_OFS) ? ctl2_rd :
                       (reg_addr == EQUALIZER_ADAPT_STATUS_OFS)  ? status_rd :
                                                       8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctl1_q      <= EQUALIZER_CONTROL_ONE_RST;
      floor_q     <= AEQ_FLOOR_RST;
      dwell_sel_q <= AEQ_DWELL_RST;
      restart_q   <= 1'b0;
      rdata_q     <= 8'h00;
    end
    else
    begin
      ctl1_q      <= ctl1_d;
      floor_q     <= floor_d;
      dwell_sel_q <= dwell_sel_d;
      restart_q   <= restart_d;
      rdata_q     <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // -----------------------------------------------------------------------
  // Lock synchroniser
  // -----------------------------------------------------------------------
  logic lock_m_q;
  logic lock_s_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lock_m_q <= 1'b0;
      lock_s_q <= 1'b0;
    end
    else
    begin
      lock_m_q <= cdr_lock;
      lock_s_q <= lock_m_q;
    end
  end

  // -----------------------------------------------------------------------
  // Search engine
  // -----------------------------------------------------------------------
  aeq_state_t              state_q;
  aeq_state_t              state_d;
  logic [AEQ_GAIN_W-1:0]   gain_q;
  logic [AEQ_GAIN_W-1:0]   gain_d;
  logic [AEQ_CNT_W-1:0]    cnt_q;
  logic [AEQ_CNT_W-1:0]    cnt_d;

  wire logic floor_on = ctl1_q[1] && ctl1_q[0];
  wire logic [3:0] start_idx = floor_on ? floor_q : AEQ_GAIN_MIN;
  // Upper end is a constant; no register reaches it
  wire logic at_max = (gain_q == AEQ_GAIN_MAX);
  wire logic [3:0] next_idx = at_max ? start_idx
                                     : gain_q + 4'h1;
  // Dwell length in clocks: base shifted by the select code
  wire logic [AEQ_CNT_W-1:0] dwell_end =
    (AEQ_CNT_W'(DWELL_BASE_CYC) << dwell_sel_q) - 24'h000001;
  wire logic dwell_done = (cnt_q >= dwell_end);

  always_comb
  begin
    state_d = state_q;
    gain_d  = gain_q;
    cnt_d   = cnt_q;
    if (restart_q)
    begin
      state_d = AEQ_ST_DWELL;
      gain_d  = start_idx;
      cnt_d   = '0;
    end
    else
    begin
      case (state_q)
        AEQ_ST_DWELL:
        begin
          if (!dwell_done)
            cnt_d = cnt_q + 24'h000001;
          else if (lock_s_q)
            state_d = AEQ_ST_HOLD;
          else
          begin
            gain_d = next_idx;
            cnt_d  = '0;
          end
        end
        AEQ_ST_HOLD:
        begin
          // Gain stays put while lock persists
          if (!lock_s_q)
          begin
            state_d = AEQ_ST_DWELL;
            gain_d  = next_idx;
            cnt_d   = '0;
          end
        end
        default:
        begin
          state_d = AEQ_ST_DWELL;
          cnt_d   = '0;
        end
      endcase
    end
  end

  // Out of reset the search starts at the minimum with no write needed
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= AEQ_ST_DWELL;
      gain_q  <= AEQ_GAIN_MIN;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      gain_q  <= gain_d;
      cnt_q   <= cnt_d;
    end
  end

  logic [3:0] gain_out_q;
  logic       locked_out_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      gain_out_q   <= AEQ_GAIN_MIN;
      locked_out_q <= 1'b0;
    end
    else
    begin
      gain_out_q   <= gain_d;
      locked_out_q <= (state_d == AEQ_ST_HOLD);
    end
  end

  assign eq_gain   = gain_out_q;
  assign eq_locked = locked_out_q;
  assign status_rd = {2'b00, lock_s_q, (state_q == AEQ_ST_HOLD), gain_q};

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_dwell_end;
    state_q == AEQ_ST_DWELL && dwell_done && !restart_q;
  endsequence

  sequence s_lock_lost;
    state_q == AEQ_ST_HOLD && !lock_s_q && !restart_q;
  endsequence

  chk_lock_sync_delay: assert property (
    $rose(lock_s_q) |-> $past(cdr_lock, 2))
    else $error("lock used before two-stage sync");

  chk_dwell_no_step: assert property (
    state_q == AEQ_ST_DWELL && !dwell_done && !restart_q
      |=> $stable(gain_q) && cnt_q == $past(cnt_q) + 24'h000001)
    else $error("gain moved before dwell ended");

  chk_hold_stable: assert property (
    state_q == AEQ_ST_HOLD && lock_s_q && !restart_q
      |=> $stable(gain_q) && state_q == AEQ_ST_HOLD)
    else $error("gain changed while locked");

  chk_loss_advance: assert property (
    s_lock_lost |=> state_q == AEQ_ST_DWELL && cnt_q == 24'h000000
      ##0 (gain_q == $past(next_idx)))
    else $error("lock loss did not advance gain");

  chk_restart_start: assert property (
    restart_d ##1 restart_q |=> state_q == AEQ_ST_DWELL
      && gain_q == $past(start_idx) && cnt_q == 24'h000000)
    else $error("restart did not return to start index");

  chk_floor_gate: assert property (
    restart_q && !(ctl1_q[1] && ctl1_q[0]) |=> gain_q == AEQ_GAIN_MIN)
    else $error("floor used without override and apply");

  chk_search_order: assert property (
    s_dwell_end ##0 (!lock_s_q && !at_max)
      |=> gain_q == $past(gain_q) + 4'h1)
    else $error("search skipped a setting");

  chk_max_wrap: assert property (
    s_dwell_end ##0 (!lock_s_q && at_max)
      |=> gain_q == $past(start_idx))
    else $error("no wrap after maximum setting");

  chk_status_read: assert property (
    reg_rd && reg_addr == EQUALIZER_ADAPT_STATUS_OFS
      |=> reg_rdata[3:0] == $past(gain_q))
    else $error("status does not show current gain");

  chk_gain_out: assert property (
    ##1 eq_gain == gain_q && eq_locked == (state_q == AEQ_ST_HOLD))
    else $error("equalizer outputs disagree with engine");

endmodule // aeq_search_ctrl

// File: verif/aeq_cdr_model.sv
// Behavioural stand-in for the recovery circuit and analog equalizer.
// Assumes eq_gain is driven from clk_sys; lock follows a target gain.
`timescale 1ns/1ps

module aeq_cdr_model
#(
  parameter int LAT = 1
)(
  input  wire logic       clk_sys,    // System clock
  input  wire logic [3:0] eq_gain,    // Gain applied by the controller
  input  wire logic [3:0] lock_gain,  // Gain at which the link locks
  output logic            cdr_lock    // Lock indication, level
);
  logic [7:0] lock_sr_q;

  // ---------------------------------------------------------------
  // Lock only at the matching gain, after LAT cycles of settling
  // ---------------------------------------------------------------
  initial lock_sr_q = 8'h00;
  always @(posedge clk_sys)
  begin
    lock_sr_q <= {lock_sr_q[6:0], eq_gain == lock_gain};
  end
  assign cdr_lock = lock_sr_q[LAT-1];
endmodule // aeq_cdr_model

// File: verif/aeq_search_ctrl_tb_top.sv
// Self-checking bench for the equalizer search controller.
// Assumes a short dwell base so a full pass takes a few hundred cycles.
`timescale 1ns/1ps

module aeq_search_ctrl_tb_top;
  import aeq_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cdr_lock;
  logic [3:0] eq_gain;
  logic       eq_locked;
  logic [3:0] lock_gain = 4'hc;
  logic [7:0] exp_q[$];
  logic       rd_seen = 1'b0;
  logic [31:0] lfsr = 32'h7ce1;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         n;

  always #2.5 clk_sys = ~clk_sys;

  aeq_search_ctrl #(.DWELL_BASE_CYC(4)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cdr_lock(cdr_lock), .eq_gain(eq_gain),
    .eq_locked(eq_locked));

  aeq_cdr_model #(.LAT(1)) cdr (
    .clk_sys(clk_sys), .eq_gain(eq_gain), .lock_gain(lock_gain),
    .cdr_lock(cdr_lock));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      conclude();
    end
  end

  // Read data lands one edge after the strobe; compare oldest note
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys)
    if (rd_seen)
    begin
      if (exp_q.size() == 0) chk(reg_rdata, 8'hxx);
      else chk(reg_rdata, exp_q.pop_front());
    end

  // ---------------------------------------------------------------
  // Bus tasks, driven at the falling edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  // Bounded wait for eq_locked to reach a level
  task automatic wait_lk(input logic lvl);
    n = 0;
    while (eq_locked !== lvl && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h0, eq_locked}, {7'h0, lvl});
  endtask

  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    n = 0;
    while (eq_gain === 4'h0 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(8'(n >= 31 && n <= 35), 8'h01);
    rd(AEQ_CTL_ONE_OFS, 8'h00);
    rd(AEQ_CTL_TWO_OFS, 8'h03);
    rd(8'h77, 8'h00);
    wr(EQUALIZER_ADAPT_STATUS_OFS, 8'hff);
    wr(8'h77, 8'hff);
    wr(AEQ_CTL_TWO_OFS, 8'h50);
    lock_gain = 4'h7;
    wr(AEQ_CTL_ONE_OFS, 8'h07);
    // Restart acts one edge after the write edge
    @(negedge clk_sys);
    chk({4'h0, eq_gain}, 8'h05);
    wait_lk(1'b1);
    rd(AEQ_CTL_ONE_OFS, 8'h06);
    rd(AEQ_CTL_TWO_OFS, 8'h50);
    rd(EQUALIZER_ADAPT_STATUS_OFS, 8'h37);
    repeat (40) @(negedge clk_sys);
    rd(EQUALIZER_ADAPT_STATUS_OFS, 8'h37);
    lock_gain = 4'h9;
    wait_lk(1'b0);
    wait_lk(1'b1);
    rd(EQUALIZER_ADAPT_STATUS_OFS, 8'h39);
    // Lock only at the floor: after the top it must wrap to 5, not 0
    lock_gain = 4'h5;
    n = 0;
    while (eq_gain !== 4'hf && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    while (eq_gain === 4'hf && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({4'h0, eq_gain}, 8'h05);
    lock_gain = 4'h2;
    wr(AEQ_CTL_ONE_OFS, 8'h03);
    @(negedge clk_sys);
    chk({4'h0, eq_gain}, 8'h00);
    wr(AEQ_CTL_ONE_OFS, 8'h05);
    @(negedge clk_sys);
    chk({4'h0, eq_gain}, 8'h00);
    wait_lk(1'b1);
    rd(EQUALIZER_ADAPT_STATUS_OFS, 8'h32);
    repeat (4)
    begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      wr(AEQ_CTL_TWO_OFS, {lfsr[3:0], 4'h0});
      lock_gain = lfsr[3:0];
      wr(AEQ_CTL_ONE_OFS, 8'h07);
      // Old lock still shows until the restart lands
      wait_lk(1'b0);
      wait_lk(1'b1);
      rd(EQUALIZER_ADAPT_STATUS_OFS, {4'h3, lfsr[3:0]});
    end
    repeat (4) @(negedge clk_sys);
    chk(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule // aeq_search_ctrl_tb_top
